// ---- pkg/mac_pkg.sv ----
package mac_pkg;

	// ----------------------------------------------------------------
	// I/O register offsets within the low address byte
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_ACC0     = 8'h80;
	localparam logic [7:0] OFF_ACC1     = 8'h81;
	localparam logic [7:0] OFF_ACC2     = 8'h82;
	localparam logic [7:0] OFF_ACC3     = 8'h83;
	localparam logic [7:0] OFF_ACC4     = 8'h84;
	localparam logic [7:0] OFF_CTL      = 8'h85;
	localparam logic [7:0] OFF_X_START  = 8'h86;
	localparam logic [7:0] OFF_X_END    = 8'h87;
	localparam logic [7:0] OFF_X_RELOAD = 8'h88;
	localparam logic [7:0] OFF_Y_START  = 8'h89;
	localparam logic [7:0] OFF_Y_END    = 8'h8a;
	localparam logic [7:0] OFF_Y_RELOAD = 8'h8b;
	localparam logic [7:0] OFF_LENGTH   = 8'h8c;
	localparam logic [7:0] OFF_STAT     = 8'h8f;

	// ----------------------------------------------------------------
	// Block transfer marker and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  LAST_XFER  = 8'h01;
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam logic [39:0] ACC_RST    = 40'h00_0000_0000;
	localparam logic [3:0]  STAT_PAD   = 4'h0;

	// ----------------------------------------------------------------
	// Bank states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HOST_EMPTY = 2'b00,
		HOST_READY = 2'b01,
		HOST_DONE  = 2'b11
	} host_state_type;

	typedef enum logic [1:0] {
		COMP_EMPTY = 2'b00,
		COMP_BUSY  = 2'b10,
		COMP_DONE  = 2'b11
	} compute_state_type;

endpackage : mac_pkg

// ---- hdl/operand_ram.sv ----
`timescale 1ns/10ps
module operand_ram (
	// Clock
	input  wire logic        ref_clk,
	// Byte port toward the CPU memory space
	input  wire logic        cpu_en,
	input  wire logic        cpu_wr,
	input  wire logic [8:0]  cpu_addr,
	input  wire logic [7:0]  cpu_wdata,
	output logic      [7:0]  cpu_rdata,
	// Word read port toward the multiplier
	input  wire logic [7:0]  calc_addr,
	output logic      [15:0] calc_rdata
);

	logic [15:0] mem [256];

	// Byte wide read/write port
	always_ff @(posedge ref_clk) begin
		if (cpu_en) begin
			if (cpu_wr) begin
				if (cpu_addr[0]) begin
					mem[cpu_addr[8:1]][15:8] <= cpu_wdata;
				end else begin
					mem[cpu_addr[8:1]][7:0] <= cpu_wdata;
				end
			end
			cpu_rdata <= cpu_addr[0] ? mem[cpu_addr[8:1]][15:8] : mem[cpu_addr[8:1]][7:0];
		end
	end

	// Word read port, registered output
	always_ff @(posedge ref_clk) begin
		calc_rdata <= mem[calc_addr];
	end

endmodule : operand_ram

// ---- hdl/mac_datapath.sv ----
`timescale 1ns/10ps
module mac_datapath (
	// Operands
	input  wire logic [15:0] x_val,
	input  wire logic [15:0] y_val,
	// Accumulator in and out
	input  wire logic [39:0] acc_in,
	output logic      [39:0] acc_out
);

	logic [31:0] product;

	// Unsigned product, sum wraps at forty bits
	always_comb begin
		product = x_val * y_val;
		acc_out = acc_in + {8'h00, product};
	end

endmodule : mac_datapath

// ---- hdl/mult_accum_unit.sv ----
// Operation
// - Multiply two 16-bit operands, add 32-bit product into selected 40-bit accumulator.
// - One multiply-accumulate step per clock while a calculation runs.
// - Two 256x16 operand memories x and y with 16-bit read port.
// - Each memory has an 8-bit read/write port on the CPU data bus.
// - Host ready and compute empty or done: swap, start, compute becomes busy.
// - Calculation defined while busy: host waits ready, swap when computation ends.
// - Calculation ends with host empty or ready: swap so CPU reads result.
// - Registers decode from low address byte; high byte flags last transfer.
// - Top accumulator write, or lower byte write at count 01h, makes host ready.
// - Control write at count 01h makes host ready and clears accumulator.
// - Top accumulator read, or lower byte read at count 01h, empties done host.
// - Any register write except to status, or one that makes host ready, empties a done host bank.
// - Accumulator readable as five byte registers.
// - Host bank state in status [1:0]: 00 empty, 01 ready, 11 done.
// - Compute bank state in status [3:2]: 00 empty, 10 busy, 11 done.
// - Each bank has own accumulator and control values, swapped as whole.
`timescale 1ns/10ps
module mult_accum_unit (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// CPU I/O port
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	// CPU memory port to operand memories
	input  wire logic        mem_x_sel,
	input  wire logic        mem_y_sel,
	input  wire logic [8:0]  mem_addr,
	input  wire logic        mem_wr,
	input  wire logic        mem_rd,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata,
	// Bank status
	output logic      [1:0]  host_state,
	output logic      [1:0]  compute_state,
	output logic             host_bank
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------

	// Lower four accumulator bytes
	function automatic logic is_acc_low(input logic [7:0] a);
		is_acc_low = (a == mac_pkg::OFF_ACC0) || (a == mac_pkg::OFF_ACC1) ||
			(a == mac_pkg::OFF_ACC2) || (a == mac_pkg::OFF_ACC3);
	endfunction : is_acc_low

	// Any register of the block
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = ((a >= mac_pkg::OFF_ACC0) && (a <= mac_pkg::OFF_LENGTH)) ||
			(a == mac_pkg::OFF_STAT);
	endfunction : reg_hit

	// Pointer advance with wrap to reload value
	function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic [7:0] e,
		input logic [7:0] r);
		next_ptr = (p == e) ? r : p + 8'h01;
	endfunction : next_ptr

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	mac_pkg::host_state_type    host_reg, host_next;
	mac_pkg::compute_state_type comp_reg, comp_next;
	logic        host_bank_reg;
	logic        swap_now;
	logic        start_now;
	logic [7:0]  lo_addr;
	logic        last_xfer;
	logic        ready_ev;
	logic        drain_ev;
	logic        wr_other;
	logic        finish;
	logic [7:0]  ctl_reg      [2];
	logic [7:0]  x_start_reg  [2];
	logic [7:0]  x_end_reg    [2];
	logic [7:0]  x_reload_reg [2];
	logic [7:0]  y_start_reg  [2];
	logic [7:0]  y_end_reg    [2];
	logic [7:0]  y_reload_reg [2];
	logic [7:0]  length_reg   [2];
	logic [39:0] acc_reg      [2];
	logic [7:0]  x_ptr_reg;
	logic [7:0]  y_ptr_reg;
	logic [7:0]  remain_reg;
	logic        issue_reg;
	logic [15:0] x_word;
	logic [15:0] y_word;
	logic [39:0] mac_sum;
	logic [7:0]  x_byte;
	logic [7:0]  y_byte;
	logic        mem_y_reg;
	logic [7:0]  io_rdata_reg;
	logic        comp_bank;

	// ----------------------------------------------------------------
	// Address and event decode
	// ----------------------------------------------------------------

	// Low byte selects, high byte marks the final block transfer
	assign lo_addr   = io_addr[7:0];
	assign last_xfer = (io_addr[15:8] == mac_pkg::LAST_XFER);
	assign comp_bank = ~host_bank_reg;

	// Writes that hand a calculation over
	assign ready_ev = io_wr && ((lo_addr == mac_pkg::OFF_ACC4) ||
		(is_acc_low(lo_addr) && last_xfer) ||
		((lo_addr == mac_pkg::OFF_CTL) && last_xfer));

	// Reads that collect a result
	assign drain_ev = io_rd && ((lo_addr == mac_pkg::OFF_ACC4) ||
		(is_acc_low(lo_addr) && last_xfer));

	// Writes that abandon a pending result
	assign wr_other = io_wr && reg_hit(lo_addr) && (lo_addr != mac_pkg::OFF_STAT);

	// Computation finished once issue and pipeline are empty
	assign finish = (comp_reg == mac_pkg::COMP_BUSY) && (remain_reg == 8'h00) && !issue_reg;

	// ----------------------------------------------------------------
	// Bank state machine
	// ----------------------------------------------------------------

	// Next bank states and swap decision
	always_comb begin
		host_next = host_reg;
		comp_next = comp_reg;
		swap_now  = 1'b0;
		start_now = 1'b0;
		if (finish) begin
			comp_next = mac_pkg::COMP_DONE;
		end
		case (host_reg)
			mac_pkg::HOST_DONE: begin
				if (wr_other || drain_ev) begin
					host_next = mac_pkg::HOST_EMPTY;
				end
			end
			default: begin
			end
		endcase
		if (ready_ev) begin
			host_next = mac_pkg::HOST_READY;
		end
		if ((host_next == mac_pkg::HOST_READY) && (comp_next != mac_pkg::COMP_BUSY)) begin
			// Old compute bank moves to the host side
			host_next = (comp_next == mac_pkg::COMP_DONE) ? mac_pkg::HOST_DONE :
				mac_pkg::HOST_EMPTY;
			comp_next = mac_pkg::COMP_BUSY;
			swap_now  = 1'b1;
			start_now = 1'b1;
		end else if ((comp_next == mac_pkg::COMP_DONE) &&
			(host_next == mac_pkg::HOST_EMPTY)) begin
			host_next = mac_pkg::HOST_DONE;
			comp_next = mac_pkg::COMP_EMPTY;
			swap_now  = 1'b1;
		end
	end

	// State registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			host_reg      <= mac_pkg::HOST_EMPTY;
			comp_reg      <= mac_pkg::COMP_EMPTY;
			host_bank_reg <= 1'b0;
		end else begin
			host_reg <= host_next;
			comp_reg <= comp_next;
			if (swap_now) begin
				host_bank_reg <= ~host_bank_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-bank control values, written into the host bank
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int b = 0; b < 2; b++) begin
				ctl_reg[b]      <= mac_pkg::BYTE_RST;
				x_start_reg[b]  <= mac_pkg::BYTE_RST;
				x_end_reg[b]    <= mac_pkg::BYTE_RST;
				x_reload_reg[b] <= mac_pkg::BYTE_RST;
				y_start_reg[b]  <= mac_pkg::BYTE_RST;
				y_end_reg[b]    <= mac_pkg::BYTE_RST;
				y_reload_reg[b] <= mac_pkg::BYTE_RST;
				length_reg[b]   <= mac_pkg::BYTE_RST;
			end
		end else if (io_wr) begin
			if (lo_addr == mac_pkg::OFF_CTL) begin
				ctl_reg[host_bank_reg] <= io_wdata;
			end else if (lo_addr == mac_pkg::OFF_X_START) begin
				x_start_reg[host_bank_reg] <= io_wdata;
			end else if (lo_addr == mac_pkg::OFF_X_END) begin
				x_end_reg[host_bank_reg] <= io_wdata;
			end else if (lo_addr == mac_pkg::OFF_X_RELOAD) begin
				x_reload_reg[host_bank_reg] <= io_wdata;
			end else if (lo_addr == mac_pkg::OFF_Y_START) begin
				y_start_reg[host_bank_reg] <= io_wdata;
			end else if (lo_addr == mac_pkg::OFF_Y_END) begin
				y_end_reg[host_bank_reg] <= io_wdata;
			end else if (lo_addr == mac_pkg::OFF_Y_RELOAD) begin
				y_reload_reg[host_bank_reg] <= io_wdata;
			end else if (lo_addr == mac_pkg::OFF_LENGTH) begin
				length_reg[host_bank_reg] <= io_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Accumulators: CPU bytes on host bank, sums on compute bank
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_reg[0] <= mac_pkg::ACC_RST;
			acc_reg[1] <= mac_pkg::ACC_RST;
		end else begin
			if (issue_reg) begin
				acc_reg[comp_bank] <= mac_sum;
			end
			if (io_wr) begin
				if (lo_addr == mac_pkg::OFF_ACC0) begin
					acc_reg[host_bank_reg][7:0] <= io_wdata;
				end else if (lo_addr == mac_pkg::OFF_ACC1) begin
					acc_reg[host_bank_reg][15:8] <= io_wdata;
				end else if (lo_addr == mac_pkg::OFF_ACC2) begin
					acc_reg[host_bank_reg][23:16] <= io_wdata;
				end else if (lo_addr == mac_pkg::OFF_ACC3) begin
					acc_reg[host_bank_reg][31:24] <= io_wdata;
				end else if (lo_addr == mac_pkg::OFF_ACC4) begin
					acc_reg[host_bank_reg][39:32] <= io_wdata;
				end else if ((lo_addr == mac_pkg::OFF_CTL) && last_xfer) begin
					acc_reg[host_bank_reg] <= mac_pkg::ACC_RST;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Operand sequencer: one address pair issued per clock
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			x_ptr_reg  <= mac_pkg::BYTE_RST;
			y_ptr_reg  <= mac_pkg::BYTE_RST;
			remain_reg <= mac_pkg::BYTE_RST;
			issue_reg  <= 1'b0;
		end else if (start_now) begin
			// Load from the bank about to become the compute bank
			x_ptr_reg  <= x_start_reg[host_bank_reg];
			y_ptr_reg  <= y_start_reg[host_bank_reg];
			remain_reg <= length_reg[host_bank_reg];
			issue_reg  <= 1'b0;
		end else if ((comp_reg == mac_pkg::COMP_BUSY) && (remain_reg != 8'h00)) begin
			x_ptr_reg  <= next_ptr(x_ptr_reg, x_end_reg[comp_bank], x_reload_reg[comp_bank]);
			y_ptr_reg  <= next_ptr(y_ptr_reg, y_end_reg[comp_bank], y_reload_reg[comp_bank]);
			remain_reg <= remain_reg - 8'h01;
			issue_reg  <= 1'b1;
		end else begin
			issue_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Operand memories and multiply-add
	// ----------------------------------------------------------------
	operand_ram x_ram (
		.ref_clk    (ref_clk),
		.cpu_en     (mem_x_sel && (mem_wr || mem_rd)),
		.cpu_wr     (mem_wr),
		.cpu_addr   (mem_addr),
		.cpu_wdata  (mem_wdata),
		.cpu_rdata  (x_byte),
		.calc_addr  (x_ptr_reg),
		.calc_rdata (x_word)
	);

	operand_ram y_ram (
		.ref_clk    (ref_clk),
		.cpu_en     (mem_y_sel && (mem_wr || mem_rd)),
		.cpu_wr     (mem_wr),
		.cpu_addr   (mem_addr),
		.cpu_wdata  (mem_wdata),
		.cpu_rdata  (y_byte),
		.calc_addr  (y_ptr_reg),
		.calc_rdata (y_word)
	);

	mac_datapath datapath (
		.x_val   (x_word),
		.y_val   (y_word),
		.acc_in  (acc_reg[comp_bank]),
		.acc_out (mac_sum)
	);

	// Remember which memory the last CPU read addressed
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mem_y_reg <= 1'b0;
		end else if (mem_rd && (mem_x_sel || mem_y_sel)) begin
			mem_y_reg <= mem_y_sel;
		end
	end

	assign mem_rdata = mem_y_reg ? y_byte : x_byte;

	// ----------------------------------------------------------------
	// I/O read data, captured on the read strobe
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			io_rdata_reg <= mac_pkg::BYTE_RST;
		end else if (io_rd) begin
			if (lo_addr == mac_pkg::OFF_ACC0) begin
				io_rdata_reg <= acc_reg[host_bank_reg][7:0];
			end else if (lo_addr == mac_pkg::OFF_ACC1) begin
				io_rdata_reg <= acc_reg[host_bank_reg][15:8];
			end else if (lo_addr == mac_pkg::OFF_ACC2) begin
				io_rdata_reg <= acc_reg[host_bank_reg][23:16];
			end else if (lo_addr == mac_pkg::OFF_ACC3) begin
				io_rdata_reg <= acc_reg[host_bank_reg][31:24];
			end else if (lo_addr == mac_pkg::OFF_ACC4) begin
				io_rdata_reg <= acc_reg[host_bank_reg][39:32];
			end else if (lo_addr == mac_pkg::OFF_CTL) begin
				io_rdata_reg <= ctl_reg[host_bank_reg];
			end else if (lo_addr == mac_pkg::OFF_X_START) begin
				io_rdata_reg <= x_start_reg[host_bank_reg];
			end else if (lo_addr == mac_pkg::OFF_X_END) begin
				io_rdata_reg <= x_end_reg[host_bank_reg];
			end else if (lo_addr == mac_pkg::OFF_X_RELOAD) begin
				io_rdata_reg <= x_reload_reg[host_bank_reg];
			end else if (lo_addr == mac_pkg::OFF_Y_START) begin
				io_rdata_reg <= y_start_reg[host_bank_reg];
			end else if (lo_addr == mac_pkg::OFF_Y_END) begin
				io_rdata_reg <= y_end_reg[host_bank_reg];
			end else if (lo_addr == mac_pkg::OFF_Y_RELOAD) begin
				io_rdata_reg <= y_reload_reg[host_bank_reg];
			end else if (lo_addr == mac_pkg::OFF_LENGTH) begin
				io_rdata_reg <= length_reg[host_bank_reg];
			end else if (lo_addr == mac_pkg::OFF_STAT) begin
				io_rdata_reg <= {mac_pkg::STAT_PAD, comp_reg, host_reg};
			end else begin
				io_rdata_reg <= mac_pkg::BYTE_RST;
			end
		end
	end

	// Outputs
	assign io_rdata      = io_rdata_reg;
	assign host_state    = host_reg;
	assign compute_state = comp_reg;
	assign host_bank     = host_bank_reg;

endmodule : mult_accum_unit

// ---- verif/mac_asserts.sv ----
`timescale 1ns/10ps
module mac_asserts (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// CPU I/O port
	input wire logic [15:0] io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_rdata,
	// Bank status
	input wire logic [1:0]  host_state,
	input wire logic [1:0]  compute_state,
	input wire logic        host_bank
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// Address decode helpers
	// ----------------------------------------------------------------
	logic       last_xfer;
	logic       low_acc;
	logic [7:0] port;
	assign port      = io_addr[7:0];
	assign last_xfer = (io_addr[15:8] == mac_pkg::LAST_XFER);
	assign low_acc   = (port >= mac_pkg::OFF_ACC0) && (port <= mac_pkg::OFF_ACC3);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_host_code;
		host_state != 2'b10;
	endproperty
	a_host_code: assert property (p_host_code) else $error("host code 10 seen");
	property p_comp_code;
		compute_state != 2'b01;
	endproperty
	a_comp_code: assert property (p_comp_code) else $error("compute code 01 seen");
	property p_start_swap;
		io_wr && port == mac_pkg::OFF_ACC4 && host_state == 2'b00 && compute_state != 2'b10
			|=> compute_state == 2'b10 && host_bank != $past(host_bank);
	endproperty
	a_start_swap: assert property (p_start_swap) else $error("no swap on top write");
	// A finish in the same cycle swaps at once, so only a held bank must show ready
	property p_wait_ready;
		io_wr && port == mac_pkg::OFF_CTL && last_xfer && host_state == 2'b00
			&& compute_state == 2'b10 ##1 compute_state == 2'b10
			&& host_bank == $past(host_bank) |-> host_state == 2'b01;
	endproperty
	a_wait_ready: assert property (p_wait_ready) else $error("host not ready");
	property p_no_ready;
		io_wr && low_acc && !last_xfer && host_state == 2'b00 && compute_state == 2'b10
			##1 compute_state == 2'b10 |-> host_state == 2'b00;
	endproperty
	a_no_ready: assert property (p_no_ready) else $error("low write made ready");
	// A waiting result may swap in on the drain edge; judge only unswapped banks
	property p_read_top;
		io_rd && port == mac_pkg::OFF_ACC4 && host_state == 2'b11
			##1 host_bank == $past(host_bank) |-> host_state == 2'b00;
	endproperty
	a_read_top: assert property (p_read_top) else $error("top read kept done");
	property p_read_low;
		io_rd && low_acc && host_state == 2'b11 ##1 host_bank == $past(host_bank)
			|-> host_state == ($past(last_xfer) ? 2'b00 : 2'b11);
	endproperty
	a_read_low: assert property (p_read_low) else $error("low read state wrong");
	property p_stat_write;
		io_wr && port == mac_pkg::OFF_STAT && host_state == 2'b11 |=> host_state == 2'b11;
	endproperty
	a_stat_write: assert property (p_stat_write) else $error("status write emptied");
	property p_write_empty;
		io_wr && port == mac_pkg::OFF_X_START && host_state == 2'b11 && compute_state == 2'b00
			|=> host_state == 2'b00;
	endproperty
	a_write_empty: assert property (p_write_empty) else $error("write kept done");
	property p_finish_swap;
		compute_state == 2'b10 && host_state == 2'b00 && !io_wr ##1 compute_state != 2'b10
			|-> host_state == 2'b11;
	endproperty
	a_finish_swap: assert property (p_finish_swap) else $error("no swap on finish");
	property p_rdata_hold;
		!io_rd |=> $stable(io_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_unmapped;
		io_rd && port == 8'h8d |=> io_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	// Main scenarios reached
	c_queued: cover property (compute_state == 2'b10 && host_state == 2'b01);
	c_result: cover property (io_rd && port == mac_pkg::OFF_ACC4 && host_state == 2'b11);
	c_define: cover property (io_wr && port == mac_pkg::OFF_CTL && last_xfer);
endmodule : mac_asserts

bind mult_accum_unit mac_asserts u_mac_asserts (.ref_clk(ref_clk), .rst(rst),
	.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
	.host_state(host_state), .compute_state(compute_state), .host_bank(host_bank));

// ---- verif/host_cpu_model.sv ----
`timescale 1ns/10ps
module host_cpu_model (
	// Clock
	input wire logic         ref_clk,
	// I/O bus toward the block
	output logic      [15:0] io_addr,
	output logic             io_wr,
	output logic             io_rd,
	output logic      [7:0]  io_wdata,
	input  wire logic [7:0]  io_rdata
);
	// Bus idle at start
	initial begin
		io_addr  = 16'h0000;
		io_wr    = 1'b0;
		io_rd    = 1'b0;
		io_wdata = 8'h00;
	end

	// One write; count on high byte, port on low, 01h only when a change is meant
	task automatic io_write(input logic [7:0] cnt, port, d);
		@(posedge ref_clk);
		io_addr  <= {cnt, port};
		io_wdata <= d;
		io_wr    <= 1'b1;
		@(posedge ref_clk);
		io_wr    <= 1'b0;
		io_addr  <= ~{cnt, port};
		io_wdata <= ~d;
	endtask : io_write

	// One read; data taken once the strobe edge has landed
	task automatic io_read(input logic [7:0] cnt, port, output logic [7:0] d);
		@(posedge ref_clk);
		io_addr <= {cnt, port};
		io_rd   <= 1'b1;
		@(posedge ref_clk);
		io_rd   <= 1'b0;
		io_addr <= ~{cnt, port};
		#1;
		d = io_rdata;
	endtask : io_read

	// Block input: count falls to 01h, port rises
	task automatic block_in(input logic [7:0] port, n, output logic [39:0] v);
		v = 40'h0;
		for (int i = 0; i < n; i++) begin
			io_read(n - 8'(i), port + 8'(i), v[8*i +: 8]);
		end
	endtask : block_in
endmodule : host_cpu_model

// ---- verif/mult_accum_unit_bench.sv ----
`timescale 1ns/10ps
`define CHK(g, e) check_val(40'(g), 40'(e))
module mult_accum_unit_bench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        ref_clk, rst, mem_x_sel, mem_y_sel, mem_wr, mem_rd;
	logic        io_wr, io_rd, host_bank;
	logic [8:0]  mem_addr;
	logic [7:0]  mem_wdata, mem_rdata, io_wdata, io_rdata;
	logic [15:0] io_addr;
	logic [1:0]  host_state, compute_state;
	logic [15:0] xv [4];
	logic [15:0] yv [4];
	logic [39:0] v;
	int          k;
	int          n_fail   = 0;
	int          n_checks = 0;

	mult_accum_unit dut (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_x_sel(mem_x_sel),
		.mem_y_sel(mem_y_sel), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .host_state(host_state),
		.compute_state(compute_state), .host_bank(host_bank));
	host_cpu_model host (.ref_clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check_val(input logic [39:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check_val

	// Pointer walk with wrap to reload, sum mod 2^40
	function automatic logic [39:0] exp_sum(input logic [7:0] s, e, r, len);
		logic [39:0] a;
		logic [7:0]  p;
		a = 40'h0;
		p = s;
		for (int i = 0; i < len; i++) begin
			a = a + xv[p[1:0]] * yv[p[1:0]];
			p = (p == e) ? r : p + 8'h01;
		end
		return a;
	endfunction : exp_sum

	task automatic mem_op(input logic sx, wr, input logic [8:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		mem_x_sel <= sx;
		mem_y_sel <= !sx;
		mem_addr  <= a;
		mem_wdata <= d;
		mem_wr    <= wr;
		mem_rd    <= !wr;
		@(posedge ref_clk);
		mem_wr    <= 1'b0;
		mem_rd    <= 1'b0;
		mem_wdata <= ~d;
		#1;
	endtask : mem_op

	// Same pointer setup for x and y, count not 01h
	task automatic setup(input logic [7:0] s, e, r, len);
		logic [7:0] vals [7];
		vals = '{s, e, r, s, e, r, len};
		for (int i = 0; i < 7; i++) begin
			host.io_write(8'h02, mac_pkg::OFF_X_START + 8'(i), vals[i]);
		end
	endtask : setup

	task automatic start_calc;
		host.io_write(mac_pkg::LAST_XFER, mac_pkg::OFF_CTL, 8'h00);
		#1;
	endtask : start_calc

	task automatic wait_host(input logic [1:0] st, output int n);
		n = 0;
		while (host_state !== st && n < 2000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		`CHK(host_state, st);
	endtask : wait_host

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		`CHK({host_state, compute_state}, 4'h0);
		`CHK({host_bank, io_rdata}, 9'h000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_mem;
		for (int i = 0; i < 4; i++) begin
			mem_op(1'b1, 1'b1, {2'(i), 7'h00} >> 6, xv[i][7:0]);
			mem_op(1'b1, 1'b1, ({2'(i), 7'h00} >> 6) | 9'h001, xv[i][15:8]);
			mem_op(1'b0, 1'b1, {2'(i), 7'h00} >> 6, yv[i][7:0]);
			mem_op(1'b0, 1'b1, ({2'(i), 7'h00} >> 6) | 9'h001, yv[i][15:8]);
		end
		mem_op(1'b1, 1'b0, 9'h003, 8'h00);
		`CHK(mem_rdata, xv[1][15:8]);
		mem_op(1'b0, 1'b0, 9'h007, 8'h00);
		`CHK(mem_rdata, yv[3][15:8]);
		$display("test memory done");
	endtask : t_mem

	task automatic t_calc;
		setup(8'h00, 8'h03, 8'h01, 8'h06);
		start_calc();
		`CHK({host_bank, compute_state, host_state}, 5'b1_10_00);
		wait_host(2'b11, k);
		`CHK(k, 8);
		`CHK(compute_state, 2'b00);
		host.block_in(mac_pkg::OFF_ACC0, 8'd5, v);
		`CHK(host_state, 2'b00);
		`CHK(v, exp_sum(8'h00, 8'h03, 8'h01, 8'h06));
		$display("test calc done");
	endtask : t_calc

	task automatic t_queue;
		setup(8'h00, 8'h03, 8'h00, 8'd200);
		start_calc();
		`CHK(compute_state, 2'b10);
		host.io_write(8'h03, mac_pkg::OFF_ACC1, 8'h55);
		#1;
		`CHK(host_state, 2'b00);
		setup(8'h01, 8'h02, 8'h01, 8'h03);
		start_calc();
		`CHK(host_state, 2'b01);
		wait_host(2'b11, k);
		`CHK(compute_state, 2'b10);
		host.block_in(mac_pkg::OFF_ACC0, 8'd2, v);
		`CHK(v[15:0], exp_sum(8'h00, 8'h03, 8'h00, 8'd200) & 40'hffff);
		`CHK(host_state, 2'b00);
		wait_host(2'b11, k);
		host.block_in(mac_pkg::OFF_ACC0, 8'd5, v);
		`CHK(v, exp_sum(8'h01, 8'h02, 8'h01, 8'h03));
		$display("test queue done");
	endtask : t_queue

	task automatic t_wrap;
		setup(8'h00, 8'h00, 8'h00, 8'h01);
		for (int i = 0; i < 4; i++) begin
			host.io_write(8'(5 - i), mac_pkg::OFF_ACC0 + 8'(i), 8'hff);
		end
		`CHK(host_state, 2'b00);
		host.io_write(8'h02, mac_pkg::OFF_ACC4, 8'hff);
		#1;
		`CHK(compute_state, 2'b10);
		wait_host(2'b11, k);
		host.io_write(8'h00, mac_pkg::OFF_STAT, 8'h00);
		#1;
		`CHK(host_state, 2'b11);
		host.io_read(8'h00, mac_pkg::OFF_STAT, v[7:0]);
		`CHK(v[7:0], 8'h03);
		host.io_read(8'h00, 8'h8d, v[7:0]);
		`CHK(v[7:0], 8'h00);
		for (int i = 0; i < 4; i++) begin
			host.io_read(8'h00, mac_pkg::OFF_ACC0 + 8'(i), v[8*i +: 8]);
		end
		`CHK(v[31:0], 32'h0000000e);
		`CHK(host_state, 2'b11);
		host.io_write(8'h00, mac_pkg::OFF_X_START, 8'h00);
		#1;
		`CHK(host_state, 2'b00);
		$display("test wrap done");
	endtask : t_wrap

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Clock, main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	initial begin
		rst       = 1'b1;
		mem_x_sel = 1'b0;
		mem_y_sel = 1'b0;
		mem_wr    = 1'b0;
		mem_rd    = 1'b0;
		mem_addr  = 9'h000;
		mem_wdata = 8'h00;
		xv = '{16'h0003, 16'hffff, 16'h1234, 16'h0010};
		yv = '{16'h0005, 16'hffff, 16'h0100, 16'h8000};
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		t_reset();
		t_mem();
		t_calc();
		t_queue();
		t_wrap();
		tally_and_finish();
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		tally_and_finish();
	end
endmodule : mult_accum_unit_bench
